//--- rdm_ctrl.sv
/*
  Mode control of a four-lane reversible redriver: straps, mode pins, USB power
  state tracking, AUX snooping, lane gating, equalizer selection, Wishbone registers.
  Assumes all inputs synchronous to I_CORE_CLK and a classic Wishbone master.
*/
`timescale 1ns/10ps
module rdm_ctrl #(
  parameter int unsigned DEB_CYC      = rdm_pkg::DEB_CYC,
  parameter int unsigned AUX_OPEN_CYC = rdm_pkg::AUX_OPEN_CYC,
  parameter int unsigned RXDET_CYC    = rdm_pkg::RXDET_CYC,
  parameter int unsigned U2_IDLE_CYC  = rdm_pkg::U2_IDLE_CYC,
  parameter int unsigned U3_IDLE_CYC  = rdm_pkg::U3_IDLE_CYC
) (
  // Clock and reset
  input  wire logic                                I_CORE_CLK,
  input  wire logic                                I_RST,
  // Register bus
  input  wire rdm_pkg::rdm_wb_req_t                I_WB,
  output logic [31:0]                              O_WB_DAT,
  output logic                                     O_WB_ACK,
  // Strap comparators and pull control
  input  wire logic [rdm_pkg::NUM_STRAPS*3-1:0]    I_STRAP_CMP,
  output logic                                     O_PULL_EN,
  // Mode pins
  input  wire logic                                I_USB_EN_CTL,
  input  wire logic                                I_ALT_EN_CTL,
  input  wire logic                                I_FLIP,
  input  wire logic [1:0]                          I_DIR,
  input  wire logic                                I_SWAP,
  // USB line conditions
  input  wire rdm_pkg::rdm_line_t                  I_LINE,
  input  wire logic [rdm_pkg::NUM_CH-1:0]          I_LFPS_DET,
  output logic                                     O_RXDET_REQ,
  output logic                                     O_RX_TERM_EN,
  output rdm_pkg::rdm_usb_t                        O_USB_STATE,
  // AUX snoop and switch
  input  wire rdm_pkg::rdm_aux_wr_t                I_AUX,
  output logic [1:0]                               O_AUX_SW,
  // Datapath control
  output rdm_pkg::rdm_mode_t                       O_MODE,
  output logic [1:0]                               O_MAP_SEL,
  output logic                                     O_FLIP_SEL,
  output logic                                     O_CH_REVERSE,
  output logic [3:0]                               O_ALT_LANE_EN,
  output logic [rdm_pkg::NUM_CH*4-1:0]             O_CH_EQ,
  output logic [rdm_pkg::NUM_CH-1:0]               O_EQ_ON,
  output logic [1:0]                               O_GAIN_CFG
);
  import rdm_pkg::*;

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [3:0] cnt_mask(input logic [4:0] cnt);
    cnt_mask = (cnt >= 5'd4) ? 4'hF : (cnt == 5'd3) ? 4'h7 : (cnt == 5'd2) ? 4'h3 : (cnt == 5'd1) ? 4'h1 : 4'h0;
  endfunction

  // Strap capture
  logic            cap_pend_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic            hold_done_w;
  logic            pull_en_q;
  rdm_lvl_t        strap_lvl [NUM_STRAPS];

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      cap_pend_q <= 1'b1;
    end else begin
      cap_pend_q <= 1'b0;
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < NUM_STRAPS; gs++) begin : g_strap
      rdm_strap_cap u_cap (
        .i_clk     (I_CORE_CLK),
        .i_rst     (I_RST),
        .i_cmp     (I_STRAP_CMP[gs*3 +: 3]),
        .i_capture (cap_pend_q),
        .o_level   (strap_lvl[gs])
      );
    end
  endgenerate

  assign hold_done_w = (hold_cnt_q == CNT_W'(CFG_HOLD_CYC));

  // Pulls stay on through reset so the straps are valid when captured
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      hold_cnt_q <= '0;
      pull_en_q  <= 1'b1;
    end else begin
      hold_cnt_q <= hold_done_w ? hold_cnt_q : hold_cnt_q + 1'b1;
      pull_en_q  <= ~hold_done_w;
    end
  end
  assign O_PULL_EN = pull_en_q;

  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] eq_lane_q;
  logic [31:0] lanes_q;
  logic [31:0] status_w;
  logic [31:0] rd_w;
  logic [31:0] rd_q;
  logic [31:0] wmask_w;
  logic        ack_q;
  logic        req_w;
  logic        wr_w;

  assign req_w   = I_WB.cyc & I_WB.stb;
  assign wr_w    = req_w & I_WB.we & ack_q;
  assign wmask_w = byte_mask(I_WB.sel);

  always_comb begin
    if (I_WB.adr == REG_CTRL) begin
      rd_w = ctrl_q;
    end else if (I_WB.adr == REG_EQ) begin
      rd_w = eq_lane_q;
    end else if (I_WB.adr == REG_LANES) begin
      rd_w = lanes_q;
    end else if (I_WB.adr == REG_STATUS) begin
      rd_w = status_w;
    end else begin
      rd_w = 32'h0000_0000;
    end
  end

  // Ack one cycle after the strobe; the write lands on the edge the master sees it
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end else begin
      ack_q <= req_w & ~ack_q;
      rd_q  <= (req_w & ~ack_q) ? rd_w : rd_q;
    end
  end
  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rd_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl_q    <= CTRL_RST;
      eq_lane_q <= EQ_RST;
      lanes_q   <= LANES_RST;
    end else if (wr_w) begin
      if (I_WB.adr == REG_CTRL) begin
        ctrl_q <= (ctrl_q & ~wmask_w) | (I_WB.dat & wmask_w);
      end else if (I_WB.adr == REG_EQ) begin
        eq_lane_q <= (eq_lane_q & ~wmask_w) | (I_WB.dat & wmask_w);
      end else if (I_WB.adr == REG_LANES) begin
        lanes_q <= (lanes_q & ~wmask_w) | (I_WB.dat & wmask_w);
      end
    end
  end

  // Configuration source
  logic       reg_mode_w;
  logic       usb_src_w;
  logic       alt_src_w;
  logic       flip_w;
  logic [1:0] dir_w;
  logic       swap_w;
  logic       snoop_off_w;

  // Level R is taken as register mode too, so only 0 and F leave the pins in charge
  assign reg_mode_w  = (strap_lvl[STRAP_HOST] == LVL_1) | (strap_lvl[STRAP_HOST] == LVL_R);
  assign usb_src_w   = reg_mode_w ? ctrl_q[CTRL_USB_EN] : I_USB_EN_CTL;
  assign alt_src_w   = reg_mode_w ? ctrl_q[CTRL_ALT_EN] : I_ALT_EN_CTL;
  assign flip_w      = reg_mode_w ? ctrl_q[CTRL_FLIP] : I_FLIP;
  assign dir_w       = reg_mode_w ? ctrl_q[CTRL_DIR_LSB +: 2] : I_DIR;
  assign swap_w      = reg_mode_w ? ctrl_q[CTRL_SWAP] : I_SWAP;
  assign snoop_off_w = ctrl_q[CTRL_SNOOP_OFF];

  // Default USB mode and its release sequence
  logic usb_def_q;
  logic usb_seen_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      usb_def_q  <= 1'b1;
      usb_seen_q <= 1'b0;
    end else begin
      usb_seen_q <= usb_seen_q | (usb_def_q & usb_src_w);
      usb_def_q  <= usb_def_q & ~(usb_seen_q & ~usb_src_w);
    end
  end

  // Alt control low-time counter, saturating, starts saturated so reset means off
  logic [CNT_W-1:0] alt_low_q;
  logic             alt_eff_w;
  logic             aux_conn_w;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      alt_low_q <= CNT_W'(DEB_CYC);
    end else if (alt_src_w) begin
      alt_low_q <= '0;
    end else if (alt_low_q < CNT_W'(DEB_CYC)) begin
      alt_low_q <= alt_low_q + 1'b1;
    end
  end

  assign alt_eff_w  = alt_src_w | (alt_low_q < CNT_W'(DEB_CYC));
  assign aux_conn_w = alt_src_w | (alt_low_q < CNT_W'(AUX_OPEN_CYC));

  // Lane allocation; the same decode serves both the DP and the custom combination
  rdm_mode_t mode_w;
  logic [3:0] avail_w;
  logic       usb_act_w;
  logic       dp_mode_w;

  assign mode_w = usb_def_q ? MODE_USB :
                  ( alt_eff_w &  usb_src_w) ? MODE_USB_ALT2 :
                  ( alt_eff_w & ~usb_src_w) ? MODE_ALT4 :
                  (~alt_eff_w &  usb_src_w) ? MODE_USB : MODE_PD;
  assign avail_w   = (mode_w == MODE_ALT4) ? 4'hF : (mode_w == MODE_USB_ALT2) ? 4'h3 : 4'h0;
  assign usb_act_w = (mode_w == MODE_USB) | (mode_w == MODE_USB_ALT2);
  assign dp_mode_w = ~dir_w[1];

  // AUX snooping
  logic       snoop_act_w;
  logic [4:0] lc_q;
  logic       pwr_d3_q;
  logic [3:0] lane_en_w;

  assign snoop_act_w = dp_mode_w & ~snoop_off_w;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      lc_q     <= LC_RST;
      pwr_d3_q <= 1'b0;
    end else if (I_AUX.vld & snoop_act_w) begin
      if (I_AUX.adr == DPCD_LANE_COUNT) begin
        lc_q <= I_AUX.dat[4:0];
      end else if (I_AUX.adr == DPCD_POWER) begin
        pwr_d3_q <= (I_AUX.dat[2:0] == PWR_D3);
      end
    end
  end

  assign lane_en_w = snoop_act_w ? (pwr_d3_q ? 4'h0 : cnt_mask(lc_q) & avail_w) :
                     dp_mode_w ? (lanes_q[3:0] & avail_w) : avail_w;

  // USB link state tracking
  rdm_usb_t         usb_q;
  rdm_usb_t         usb_d;
  logic [CNT_W-1:0] idle_q;
  logic [CNT_W-1:0] rxdet_cnt_q;
  logic             rxdet_q;
  logic             idle_run_w;

  assign idle_run_w = I_LINE.elec_idle & ~(|I_LFPS_DET);

  always_comb begin
    usb_d = usb_q;
    case (usb_q)
      USB_DISC: usb_d = I_LINE.far_term ? USB_U0 : USB_DISC;
      USB_U0:   usb_d = I_LINE.elec_idle ? USB_U1 : USB_U0;
      USB_U1:   usb_d = (I_LINE.ss_active & ~I_LINE.elec_idle) ? USB_U0 :
                        (idle_q >= CNT_W'(U2_IDLE_CYC)) ? USB_U2 : USB_U1;
      USB_U2:   usb_d = (I_LINE.ss_active & ~I_LINE.elec_idle) ? USB_U0 :
                        (idle_q >= CNT_W'(U3_IDLE_CYC)) ? USB_U3 : USB_U2;
      USB_U3:   usb_d = (I_LINE.ss_active & ~I_LINE.elec_idle) ? USB_U0 : USB_U3;
      default:  usb_d = USB_DISC;
    endcase
    if (~usb_act_w | ~I_LINE.far_term) begin
      usb_d = USB_DISC;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      usb_q  <= USB_DISC;
      idle_q <= '0;
    end else begin
      usb_q  <= usb_d;
      idle_q <= (idle_run_w & (usb_d == usb_q)) ? idle_q + 1'b1 : '0;
    end
  end

  // Periodic receiver detection while nothing is attached
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rxdet_cnt_q <= '0;
      rxdet_q     <= 1'b0;
    end else if ((usb_q == USB_DISC) & usb_act_w) begin
      rxdet_q     <= (rxdet_cnt_q == CNT_W'(RXDET_CYC - 1));
      rxdet_cnt_q <= (rxdet_cnt_q == CNT_W'(RXDET_CYC - 1)) ? '0 : rxdet_cnt_q + 1'b1;
    end else begin
      rxdet_q     <= 1'b0;
      rxdet_cnt_q <= '0;
    end
  end

  assign O_RXDET_REQ  = rxdet_q;
  assign O_RX_TERM_EN = (usb_q != USB_DISC);
  assign O_USB_STATE  = usb_q;

  // Equalizer selection per channel
  logic [1:0]       usb_rx_ch_w;
  logic [3:0]       ueq_w;
  logic [3:0]       deq_w;
  logic [NUM_CH*4-1:0] eq_w;
  logic [NUM_CH*4-1:0] eq_q;
  logic [NUM_CH-1:0]   eq_on_q;

  assign usb_rx_ch_w = (flip_w ^ dir_w[0]) ? CH_RX2 : CH_RX1;
  assign ueq_w = reg_mode_w ? ctrl_q[CTRL_UEQ_LSB +: 4] : {strap_lvl[STRAP_UEQ1], strap_lvl[STRAP_UEQ0]};
  assign deq_w = reg_mode_w ? ctrl_q[CTRL_DEQ_LSB +: 4] : {strap_lvl[STRAP_DEQ1], strap_lvl[STRAP_DEQ0]};

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      logic       dn_in_w;
      logic [2:0] nib_w;
      // Reversal turns every input around, so the facing and its EQ swap with it
      assign dn_in_w = (usb_act_w & (usb_rx_ch_w == 2'(gc))) ^ swap_w;
      assign nib_w   = {dn_in_w, 2'(gc)};
      assign eq_w[gc*4 +: 4] = (reg_mode_w & ctrl_q[CTRL_PER_LANE]) ? eq_lane_q[nib_w*4 +: 4] :
                               dn_in_w ? deq_w : ueq_w;
    end
  endgenerate

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      eq_q    <= '0;
      eq_on_q <= '0;
    end else begin
      eq_q    <= eq_w;
      eq_on_q <= ~I_LFPS_DET;
    end
  end
  assign O_CH_EQ = eq_q;
  assign O_EQ_ON = eq_on_q;

  // Registered datapath controls
  rdm_mode_t  mode_q;
  logic [1:0] map_q;
  logic       flip_q;
  logic       rev_q;
  logic [3:0] lane_q;
  logic [1:0] gain_q;
  logic [1:0] aux_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      mode_q <= MODE_USB;
      map_q  <= 2'b00;
      flip_q <= 1'b0;
      rev_q  <= 1'b0;
      lane_q <= 4'h0;
      gain_q <= 2'b00;
      aux_q  <= 2'b00;
    end else begin
      mode_q <= mode_w;
      map_q  <= dir_w;
      flip_q <= (mode_w != MODE_PD) & flip_w;
      rev_q  <= swap_w;
      lane_q <= lane_en_w;
      gain_q <= reg_mode_w ? ctrl_q[CTRL_GAIN_LSB +: 2] : strap_lvl[STRAP_GAIN];
      aux_q  <= aux_conn_w ? (flip_w ? 2'b10 : 2'b01) : 2'b00;
    end
  end

  assign O_MODE        = mode_q;
  assign O_MAP_SEL     = map_q;
  assign O_FLIP_SEL    = flip_q;
  assign O_CH_REVERSE  = rev_q;
  assign O_ALT_LANE_EN = lane_q;
  assign O_GAIN_CFG    = gain_q;
  assign O_AUX_SW      = aux_q;

  assign status_w = {13'h0000, usb_q, lane_q, lc_q, pwr_d3_q, usb_def_q, reg_mode_w, strap_lvl[STRAP_HOST], mode_q};

  // Checks
  property p_pin_usb;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (~reg_mode_w & ~usb_def_q & I_USB_EN_CTL & ~I_ALT_EN_CTL & (alt_low_q >= CNT_W'(DEB_CYC))) |=> (O_MODE == MODE_USB);
  endproperty
  a_pin_usb: assert property (p_pin_usb) else $error("pin mode USB not followed");

  property p_pull_hold;
    @(posedge I_CORE_CLK) $fell(I_RST) |-> O_PULL_EN [*8];
  endproperty
  a_pull_hold: assert property (p_pull_hold) else $error("pulls dropped before hold time");

  property p_pull_off;
    @(posedge I_CORE_CLK) disable iff (I_RST) hold_done_w |=> ~O_PULL_EN;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pulls still on after hold time");

  property p_lfps_eq;
    @(posedge I_CORE_CLK) disable iff (I_RST) I_LFPS_DET[0] |=> ~O_EQ_ON[0];
  endproperty
  a_lfps_eq: assert property (p_lfps_eq) else $error("EQ active during LFPS");

  property p_lane_cnt;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_AUX.vld & snoop_act_w & (I_AUX.adr == DPCD_LANE_COUNT) & (I_AUX.dat == 8'h01))
      ##1 (snoop_act_w & ~pwr_d3_q & (mode_w == MODE_ALT4)) |=> (O_ALT_LANE_EN == 4'h1);
  endproperty
  a_lane_cnt: assert property (p_lane_cnt) else $error("lane enables differ from lane count");

  property p_d3_off;
    @(posedge I_CORE_CLK) disable iff (I_RST) (snoop_act_w & pwr_d3_q) |=> (O_ALT_LANE_EN == 4'h0);
  endproperty
  a_d3_off: assert property (p_d3_off) else $error("lanes on in D3");

  property p_aux_route;
    @(posedge I_CORE_CLK) disable iff (I_RST) (alt_src_w & ~flip_w) |=> (O_AUX_SW == 2'b01);
  endproperty
  a_aux_route: assert property (p_aux_route) else $error("AUX not straight");

  property p_debounce;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      ($fell(alt_src_w) & ((O_MODE == MODE_ALT4) | (O_MODE == MODE_USB_ALT2)))
      |=> ((O_MODE == MODE_ALT4) | (O_MODE == MODE_USB_ALT2)) [*8];
  endproperty
  a_debounce: assert property (p_debounce) else $error("alt lanes dropped inside debounce");

  property p_default_usb;
    @(posedge I_CORE_CLK) disable iff (I_RST) usb_def_q |=> (O_MODE == MODE_USB);
  endproperty
  a_default_usb: assert property (p_default_usb) else $error("not USB while default");

  property p_pd_flip;
    @(posedge I_CORE_CLK) disable iff (I_RST) (O_MODE == MODE_PD) |-> ~O_FLIP_SEL;
  endproperty
  a_pd_flip: assert property (p_pd_flip) else $error("flip shown in power down");

endmodule

//--- rdm_pkg.sv
/*
  Shared constants, types and register map of the redriver mode control block.
  Assumes a 100 MHz core clock; analog comparators and AUX decoding live outside.
*/
package rdm_pkg;

  // Clock and counter sizing
  localparam int CLK_MHZ          = 100;
  localparam int CNT_W            = 24;

  // Times as specified, then derived cycle counts
  localparam int DEB_TIME_MS      = 3;
  localparam int DEB_CYC          = DEB_TIME_MS * 1000 * CLK_MHZ;
  localparam int AUX_OPEN_TIME_MS = 2;
  localparam int AUX_OPEN_CYC     = AUX_OPEN_TIME_MS * 1000 * CLK_MHZ;
  localparam int RXDET_TIME_MS    = 12;
  localparam int RXDET_CYC        = RXDET_TIME_MS * 1000 * CLK_MHZ;
  localparam int CFG_HOLD_TIME_US = 10;
  localparam int CFG_HOLD_CYC     = CFG_HOLD_TIME_US * CLK_MHZ;
  localparam int U2_IDLE_TIME_US  = 100;
  localparam int U2_IDLE_CYC      = U2_IDLE_TIME_US * CLK_MHZ;
  localparam int U3_IDLE_TIME_MS  = 1;
  localparam int U3_IDLE_CYC      = U3_IDLE_TIME_MS * 1000 * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_EQ     = 8'h04;
  localparam logic [7:0] REG_LANES  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_USB_EN    = 0;
  localparam int CTRL_ALT_EN    = 1;
  localparam int CTRL_FLIP      = 2;
  localparam int CTRL_DIR_LSB   = 3;
  localparam int CTRL_SWAP      = 5;
  localparam int CTRL_SNOOP_OFF = 6;
  localparam int CTRL_GAIN_LSB  = 8;
  localparam int CTRL_PER_LANE  = 10;
  localparam int CTRL_UEQ_LSB   = 12;
  localparam int CTRL_DEQ_LSB   = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] EQ_RST     = 32'h0000_0000;
  localparam logic [31:0] LANES_RST  = 32'h0000_000F;
  localparam logic [4:0]  LC_RST     = 5'h04;

  // Sink register addresses watched on AUX
  localparam logic [19:0] DPCD_LANE_COUNT = 20'h00101;
  localparam logic [19:0] DPCD_POWER      = 20'h00600;
  localparam logic [2:0]  PWR_D3          = 3'h2;

  // Strap slots
  localparam int STRAP_HOST = 0;
  localparam int STRAP_UEQ1 = 1;
  localparam int STRAP_UEQ0 = 2;
  localparam int STRAP_DEQ1 = 3;
  localparam int STRAP_DEQ0 = 4;
  localparam int STRAP_GAIN = 5;
  localparam int NUM_STRAPS = 6;

  // Channels: RX1, TX1, TX2, RX2
  localparam int NUM_CH  = 4;
  localparam logic [1:0] CH_RX1 = 2'h0;
  localparam logic [1:0] CH_RX2 = 2'h3;

  typedef enum logic [1:0] {
    LVL_0 = 2'b00,
    LVL_R = 2'b01,
    LVL_F = 2'b10,
    LVL_1 = 2'b11
  } rdm_lvl_t;

  typedef enum logic [1:0] {
    MODE_PD       = 2'b00,
    MODE_USB      = 2'b01,
    MODE_USB_ALT2 = 2'b10,
    MODE_ALT4     = 2'b11
  } rdm_mode_t;

  typedef enum logic [2:0] {
    USB_DISC = 3'b000,
    USB_U0   = 3'b001,
    USB_U1   = 3'b010,
    USB_U2   = 3'b011,
    USB_U3   = 3'b100
  } rdm_usb_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rdm_wb_req_t;

  typedef struct packed {
    logic        vld;
    logic [19:0] adr;
    logic [7:0]  dat;
  } rdm_aux_wr_t;

  typedef struct packed {
    logic far_term;
    logic elec_idle;
    logic ss_active;
  } rdm_line_t;

endpackage

//--- rdm_strap_cap.sv
/*
  Decodes one multi-level strap from its comparator thermometer code and holds it.
  Assumes comparator outputs are settled when the capture strobe arrives.
*/
`timescale 1ns/10ps
module rdm_strap_cap (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Comparators and capture strobe
  input  wire logic [2:0]  i_cmp,
  input  wire logic        i_capture,
  // Latched level
  output rdm_pkg::rdm_lvl_t o_level
);
  import rdm_pkg::*;

  rdm_lvl_t lvl_w;
  rdm_lvl_t lvl_q;

  // Highest comparator wins so a torn thermometer code still lands on a level
  assign lvl_w = i_cmp[2] ? LVL_1 :
                 i_cmp[1] ? LVL_F :
                 i_cmp[0] ? LVL_R : LVL_0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvl_q <= LVL_F;
    end else if (i_capture) begin
      lvl_q <= lvl_w;
    end
  end

  assign o_level = lvl_q;

endmodule

//--- rdm_pd_model.sv
/* PD controller model driving the mode control pins.
   Assumes the bench gives the wanted pin pair after start-up. */
`timescale 1ns/10ps
module rdm_pd_model (
  // Clock, reset and wanted pins
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_ctl,
  // Mode pins
  output logic            o_usb_en,
  output logic            o_alt_en
);
  logic [3:0] cnt_q;
  wire        ready = (cnt_q == 4'hF);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
    end else if (!ready) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Leave the default USB mode with a low-high-low pulse before obeying
  assign o_usb_en = ready ? i_ctl[0] : (cnt_q[3:2] == 2'h1);
  assign o_alt_en = ready & i_ctl[1];
endmodule

//--- altmode_redriver_mode_control_tb.sv
/* Self-checking bench of the redriver mode control.
   Assumes pin-mode straps until a mid-run reset into register mode, and the PD controller model on the mode pins. */
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; $display("ERROR %0t %h %h", $time, a, e); end end
module altmode_redriver_mode_control_tb;
  import rdm_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, flip = 1'b0, swap = 1'b0;
  logic [1:0]  ctl = 2'h0, dir = 2'h0, aux_sw, map_sel, gain;
  logic [3:0]  lfps = 4'h0, lanes, eq_on;
  logic [15:0] ch_eq;
  logic [17:0] strap = 18'h18678;
  logic [31:0] wb_dat, rd;
  logic        usb_en, alt_en, ack, pull, rxdet, term, fsel, rev;
  rdm_wb_req_t wb = '0;
  rdm_line_t   line = '0;
  rdm_aux_wr_t aux = '0;
  rdm_usb_t    ust;
  rdm_mode_t   mode;
  int          err_count = 0, checks = 0, n;
  always #5 clk = ~clk;
  rdm_pd_model pd (.i_clk(clk), .i_rst(rst), .i_ctl(ctl), .o_usb_en(usb_en), .o_alt_en(alt_en));
  // Short counts keep the run brief
  rdm_ctrl #(.DEB_CYC(40), .AUX_OPEN_CYC(30), .RXDET_CYC(20), .U2_IDLE_CYC(10), .U3_IDLE_CYC(30)) dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_WB(wb), .O_WB_DAT(wb_dat), .O_WB_ACK(ack),
    .I_STRAP_CMP(strap), .O_PULL_EN(pull), .I_USB_EN_CTL(usb_en),
    .I_ALT_EN_CTL(alt_en), .I_FLIP(flip), .I_DIR(dir), .I_SWAP(swap), .I_LINE(line),
    .I_LFPS_DET(lfps), .O_RXDET_REQ(rxdet), .O_RX_TERM_EN(term), .O_USB_STATE(ust),
    .I_AUX(aux), .O_AUX_SW(aux_sw), .O_MODE(mode), .O_MAP_SEL(map_sel), .O_FLIP_SEL(fsel),
    .O_CH_REVERSE(rev), .O_ALT_LANE_EN(lanes), .O_CH_EQ(ch_eq), .O_EQ_ON(eq_on), .O_GAIN_CFG(gain));
  function automatic rdm_mode_t exp_mode(input logic [1:0] c);
    return c[1] ? (c[0] ? MODE_USB_ALT2 : MODE_ALT4) : (c[0] ? MODE_USB : MODE_PD);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = wb_dat;
    wb <= '0;
    if (ack !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic aux_wr(input logic [19:0] a, input logic [7:0] d);
    aux <= '{1'b1, a, d};
    tick(1);
    aux <= '0;
    tick(3);
  endtask
  initial begin
    void'($urandom(32'h4665782B));
    tick(12);
    rst <= 1'b0;
    tick(3);
    `CHK(mode, MODE_USB)
    `CHK(pull, 1'b1)
    ctl <= 2'h1;
    tick(20);
    wb_io(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[4:0], 5'h01)
    wb_io(1'b0, REG_LANES, 32'h0);
    `CHK(rd, LANES_RST)
    wb_io(1'b1, REG_EQ, 32'h1234ABCD);
    wb_io(1'b0, REG_EQ, 32'h0);
    `CHK(rd, 32'h1234ABCD)
    wb_io(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    n = 0;
    repeat (65) begin
      tick(1);
      n += rxdet;
    end
    `CHK(n >= 3, 1'b1)
    line <= 3'b100;
    tick(3);
    `CHK(ust, USB_U0)
    `CHK(term, 1'b1)
    line <= 3'b110;
    tick(3);
    `CHK(ust, USB_U1)
    tick(12);
    `CHK(ust, USB_U2)
    tick(30);
    `CHK(ust, USB_U3)
    line <= 3'b101;
    tick(3);
    `CHK(ust, USB_U0)
    `CHK(ch_eq, 16'hDDD8)
    `CHK(gain, 2'h2)
    swap <= 1'b1;
    tick(3);
    `CHK(ch_eq, 16'h888D)
    `CHK(rev, 1'b1)
    swap <= 1'b0;
    repeat (4) begin
      lfps <= 4'($urandom);
      tick(3);
      `CHK(eq_on, ~lfps)
    end
    for (int i = 0; i < 16; i++) begin
      dir <= 2'(i >> 2);
      ctl <= 2'(i);
      flip <= 1'($urandom);
      tick(50);
      `CHK(mode, exp_mode(2'(i)))
      `CHK(map_sel, 2'(i >> 2))
      if (i % 4 != 0) `CHK(fsel, flip)
      else `CHK(fsel, 1'b0)
      `CHK(aux_sw, i[1] ? {flip, ~flip} : 2'h0)
    end
    dir <= 2'h0;
    ctl <= 2'h2;
    tick(50);
    ctl <= 2'h0;
    tick(35);
    `CHK(mode, MODE_ALT4)
    tick(10);
    `CHK(mode, MODE_PD)
    ctl <= 2'h2;
    tick(50);
    for (int k = 1; k < 5; k++) begin
      aux_wr(DPCD_LANE_COUNT, 8'(k));
      `CHK(lanes, 4'((1 << k) - 1))
    end
    aux_wr(DPCD_POWER, 8'(PWR_D3));
    `CHK(lanes, 4'h0)
    aux_wr(20'h00102, 8'h01);
    aux_wr(DPCD_POWER, 8'h01);
    `CHK(lanes, 4'hF)
    `CHK(pull, 1'b0)
    // Mid-run reset into register mode while the pins still ask for four alt lanes
    strap <= 18'h1867F;
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(3);
    `CHK(mode, MODE_USB)
    `CHK(pull, 1'b1)
    wb_io(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[4:0], 5'h1D)
    wb_io(1'b1, REG_CTRL, 32'h0000_0001);
    wb_io(1'b1, REG_CTRL, 32'h0000_0000);
    wb_io(1'b1, REG_EQ, 32'h1234ABCD);
    wb_io(1'b1, REG_CTRL, 32'h0000_054F);
    tick(3);
    `CHK(mode, MODE_USB_ALT2)
    `CHK(map_sel, 2'h1)
    `CHK(fsel, 1'b1)
    `CHK(gain, 2'h1)
    `CHK(ch_eq, 16'hABC4)
    `CHK(lanes, 4'h3)
    wb_io(1'b1, REG_LANES, 32'h0000_0001);
    aux_wr(DPCD_POWER, 8'(PWR_D3));
    `CHK(lanes, 4'h1)
    report_and_stop();
  end
endmodule
